// File: rtl/exc_seq_pkg.sv
// Contract
// [RL1] Push status register, then program counter, then vector.
// [RL2] Trap pushes address after the trap.
// [RL3] Trap vector number comes from the instruction.
// [RL4] Handler entry is an immediate jump.
// [RL5] Undefined code in slot raises slot exception.
// [RL6] PC-rewriting code in slot raises slot exception.
// [RL7] Slot exception pushes the branch target.
// [RL8] Ten delayed branches open a slot.
// [RL9] Slot-illegal set adds jump_if and trap.
// [RL10] Undefined code elsewhere pushes its own address.
// [RL11] Events after delayed branch are held.
// [RL12] After control transfer defer bus/interrupt, accept FPU.
// [RL13] Eight control transfer instructions disable interrupts.
// [RL14] Stack pointer ends at saved PC, status above.
// [RL15] Software keeps stack pointer word aligned.
// [RL16] Software keeps vector base word aligned.
// [RL17] Stacking address error follows current entry.
// [RL18] Address errors ignored while stacking address error.
// [RL19] Misaligned write still issued, pointer drops four.
package exc_seq_pkg;
   localparam logic [31:0] word_step       = 32'h0000_0004;
   localparam logic [7:0]  vec_gen_illegal = 8'h04;
   localparam logic [7:0]  vec_slot_illegal = 8'h06;
   localparam logic [7:0]  vec_addr_error  = 8'h09;
   localparam logic [1:0]  fwd_addr_offset = 2'h0;

   typedef enum logic [4:0] {
      op_other                     = 5'h00,
      op_undefined                 = 5'h01,
      op_jump_absolute             = 5'h02,
      op_jump_to_subroutine        = 5'h03,
      op_relative_jump_always      = 5'h04,
      op_call_relative             = 5'h05,
      op_return_from_subroutine    = 5'h06,
      op_return_from_exception     = 5'h07,
      op_delayed_jump_if_false     = 5'h08,
      op_delayed_jump_if_true      = 5'h09,
      op_far_relative_call         = 5'h0A,
      op_far_relative_jump         = 5'h0B,
      op_jump_if_true              = 5'h0C,
      op_jump_if_false             = 5'h0D,
      op_trap                      = 5'h0E,
      op_load_control_reg          = 5'h0F,
      op_load_control_reg_from_mem = 5'h10,
      op_store_control_reg         = 5'h11,
      op_store_control_reg_to_mem  = 5'h12,
      op_load_system_reg           = 5'h13,
      op_load_system_reg_from_mem  = 5'h14,
      op_store_system_reg          = 5'h15,
      op_store_system_reg_to_mem   = 5'h16
   } op_class_t;

   typedef enum logic [2:0] {
      st_idle   = 3'h0,
      st_push_sr = 3'h1,
      st_push_pc = 3'h2,
      st_vec    = 3'h3,
      st_jump   = 3'h4
   } seq_state_t;
endpackage

// File: rtl/exc_bus_if.sv
`timescale 1ns/1ps
interface exc_bus_if;
   logic        req;
   logic        we;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic        done;
   logic [31:0] rdata;
   logic        addr_err;
   modport seq (output req, output we, output addr, output wdata, input done, input rdata, input addr_err);
   modport port (input req, input we, input addr, input wdata, output done, output rdata, output addr_err);
endinterface

// File: rtl/exc_bus_port.sv
`timescale 1ns/1ps
module exc_bus_port (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic ce,
   exc_bus_if.port   bi,
   output logic        mem_req,
   output logic        mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata,
   input  wire logic        mem_addr_err
);
   logic busy;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busy      <= 1'b0;
         mem_addr  <= 32'h0000_0000;
         mem_wdata <= 32'h0000_0000;
         mem_we    <= 1'b0;
      end else if (ce) begin
         if (!busy && bi.req) begin
            busy      <= 1'b1;
            mem_addr  <= bi.addr;
            mem_wdata <= bi.wdata;
            mem_we    <= bi.we;
         end else if (busy && mem_ack) begin
            busy <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bi.rdata    <= 32'h0000_0000;
         bi.done     <= 1'b0;
         bi.addr_err <= 1'b0;
      end else if (ce) begin
         bi.done     <= busy && mem_ack;
         bi.addr_err <= busy && mem_ack && mem_addr_err;
         if (busy && mem_ack) begin
            bi.rdata <= mem_rdata;
         end
      end
   end

   assign mem_req = busy;
endmodule

// File: rtl/instruction_exception_sequencer.sv
`timescale 1ns/1ps
module instruction_exception_sequencer (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        ce,
   input  wire logic        dec_valid,
   input  wire logic [4:0]  dec_class,
   input  wire logic [7:0]  dec_trap_vec,
   input  wire logic [31:0] dec_pc,
   input  wire logic [31:0] dec_next_pc,
   input  wire logic [31:0] branch_target,
   input  wire logic [31:0] status_register,
   input  wire logic [31:0] stack_pointer,
   input  wire logic [31:0] vector_base_register,
   input  wire logic        bus_err_req,
   input  wire logic        irq_req,
   input  wire logic [7:0]  irq_vec,
   input  wire logic        fpu_exc_req,
   input  wire logic [7:0]  fpu_vec,
   output logic        busy,
   output logic        take_bus_err,
   output logic        take_irq,
   output logic        take_fpu,
   output logic        jump_valid,
   output logic [31:0] jump_addr,
   output logic        jump_delayed,
   output logic        sp_write,
   output logic [31:0] sp_value,
   output logic        mem_req,
   output logic        mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata,
   input  wire logic        mem_addr_err
);
   exc_bus_if bi ();

   exc_bus_port u_port (
      .clk          (clk),
      .rstn         (rstn),
      .ce           (ce),
      .bi           (bi),
      .mem_req      (mem_req),
      .mem_we       (mem_we),
      .mem_addr     (mem_addr),
      .mem_wdata    (mem_wdata),
      .mem_ack      (mem_ack),
      .mem_rdata    (mem_rdata),
      .mem_addr_err (mem_addr_err)
   );

   exc_seq_pkg::seq_state_t state;
   exc_seq_pkg::op_class_t  op;
   logic        in_slot;
   logic        after_ctl;
   logic        issued;
   logic [31:0] sp;
   logic [31:0] save_pc;
   logic [31:0] save_sr;
   logic [7:0]  vec;
   logic        in_ae;
   logic        ae_pending;
   logic        is_delayed;
   logic        is_rewrite;
   logic        is_ctl;
   logic        slot_bad;
   logic        gen_bad;
   logic        trap_go;
   logic        start;
   logic        ev_ok;
   logic        bus_ok;
   logic        fpu_ok;

   assign op = exc_seq_pkg::op_class_t'(dec_class);

   always_comb begin
      is_delayed = 1'b0;
      is_ctl     = 1'b0;
      case (op)
         exc_seq_pkg::op_jump_absolute, exc_seq_pkg::op_jump_to_subroutine,
         exc_seq_pkg::op_relative_jump_always, exc_seq_pkg::op_call_relative,
         exc_seq_pkg::op_return_from_subroutine, exc_seq_pkg::op_return_from_exception,
         exc_seq_pkg::op_delayed_jump_if_false, exc_seq_pkg::op_delayed_jump_if_true,
         exc_seq_pkg::op_far_relative_call, exc_seq_pkg::op_far_relative_jump: begin
            is_delayed = 1'b1; // [RL8]
         end
         exc_seq_pkg::op_load_control_reg, exc_seq_pkg::op_load_control_reg_from_mem,
         exc_seq_pkg::op_store_control_reg, exc_seq_pkg::op_store_control_reg_to_mem,
         exc_seq_pkg::op_load_system_reg, exc_seq_pkg::op_load_system_reg_from_mem,
         exc_seq_pkg::op_store_system_reg, exc_seq_pkg::op_store_system_reg_to_mem: begin
            is_ctl = 1'b1; // [RL13]
         end
         default: begin
            is_delayed = 1'b0;
         end
      endcase
   end

   assign is_rewrite = is_delayed || op == exc_seq_pkg::op_jump_if_true || op == exc_seq_pkg::op_jump_if_false
                       || op == exc_seq_pkg::op_trap; // [RL9]

   assign start    = dec_valid && state == exc_seq_pkg::st_idle && !ae_pending;
   assign slot_bad = start && in_slot && (op == exc_seq_pkg::op_undefined || is_rewrite); // [RL5] [RL6]
   assign gen_bad  = start && !in_slot && op == exc_seq_pkg::op_undefined; // [RL10]
   assign trap_go  = start && !in_slot && op == exc_seq_pkg::op_trap; // [RL2]

   // Asynchronous events are taken only at a decode that may accept them.
   assign ev_ok  = start && !in_slot && !slot_bad && !gen_bad && !trap_go; // [RL11]
   assign bus_ok = ev_ok && !after_ctl && bus_err_req; // [RL12]
   assign fpu_ok = ev_ok && !bus_ok && fpu_exc_req; // [RL12]

   assign take_bus_err = bus_ok;
   assign take_fpu     = fpu_ok;
   assign take_irq     = ev_ok && !after_ctl && !bus_ok && !fpu_ok && irq_req; // [RL11] [RL12]
   assign busy         = state != exc_seq_pkg::st_idle || ae_pending;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         in_slot   <= 1'b0;
         after_ctl <= 1'b0;
      end else if (ce && start) begin
         // An accepted event pre-empts the decoded instruction, so it opens no slot.
         in_slot   <= !in_slot && is_delayed && !slot_bad && !(take_bus_err || take_irq || take_fpu); // [RL11]
         after_ctl <= is_ctl && !(take_bus_err || take_irq || take_fpu); // [RL12]
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state      <= exc_seq_pkg::st_idle;
         issued     <= 1'b0;
         sp         <= 32'h0000_0000;
         save_pc    <= 32'h0000_0000;
         save_sr    <= 32'h0000_0000;
         vec        <= 8'h00;
         in_ae      <= 1'b0;
         ae_pending <= 1'b0;
      end else if (ce) begin
         case (state)
            exc_seq_pkg::st_idle: begin
               if (ae_pending) begin
                  ae_pending <= 1'b0; // [RL17]
                  in_ae      <= 1'b1;
                  vec        <= exc_seq_pkg::vec_addr_error;
                  save_sr    <= status_register;
                  sp         <= stack_pointer;
                  state      <= exc_seq_pkg::st_push_sr;
               end else if (slot_bad || gen_bad || trap_go || take_bus_err || take_irq || take_fpu) begin
                  in_ae   <= take_bus_err;
                  save_sr <= status_register;
                  sp      <= stack_pointer;
                  state   <= exc_seq_pkg::st_push_sr;
                  if (slot_bad) begin
                     save_pc <= branch_target; // [RL7]
                     vec     <= exc_seq_pkg::vec_slot_illegal;
                  end else if (gen_bad) begin
                     save_pc <= dec_pc; // [RL10]
                     vec     <= exc_seq_pkg::vec_gen_illegal;
                  end else if (trap_go) begin
                     save_pc <= dec_next_pc; // [RL2]
                     vec     <= dec_trap_vec; // [RL3]
                  end else begin
                     save_pc <= dec_pc;
                     vec     <= take_bus_err ? exc_seq_pkg::vec_addr_error : (take_fpu ? fpu_vec : irq_vec);
                  end
               end
            end
            exc_seq_pkg::st_push_sr, exc_seq_pkg::st_push_pc, exc_seq_pkg::st_vec: begin
               if (!issued) begin
                  issued <= 1'b1;
               end else if (bi.done) begin
                  issued <= 1'b0;
                  if (bi.addr_err && !in_ae) begin
                     ae_pending <= 1'b1; // [RL17] [RL18]
                  end
                  if (state == exc_seq_pkg::st_push_sr) begin
                     sp    <= sp - exc_seq_pkg::word_step; // [RL19]
                     state <= exc_seq_pkg::st_push_pc; // [RL1]
                  end else if (state == exc_seq_pkg::st_push_pc) begin
                     sp    <= sp - exc_seq_pkg::word_step; // [RL14]
                     state <= exc_seq_pkg::st_vec;
                  end else begin
                     save_pc <= bi.rdata;
                     state   <= exc_seq_pkg::st_jump;
                  end
               end
            end
            exc_seq_pkg::st_jump: begin
               in_ae <= 1'b0;
               state <= exc_seq_pkg::st_idle;
            end
            default: begin
               state <= exc_seq_pkg::st_idle;
            end
         endcase
      end
   end

   // Stack writes go out at the pre-decremented pointer even when misaligned.
   always_comb begin
      bi.req   = ce && !issued && (state == exc_seq_pkg::st_push_sr || state == exc_seq_pkg::st_push_pc
                 || state == exc_seq_pkg::st_vec);
      bi.we    = state != exc_seq_pkg::st_vec;
      bi.addr  = vector_base_register + {22'h000000, vec, 2'h0};
      bi.wdata = save_sr;
      if (state == exc_seq_pkg::st_push_sr) begin
         bi.addr = sp - exc_seq_pkg::word_step; // [RL19]
      end else if (state == exc_seq_pkg::st_push_pc) begin
         bi.addr  = sp - exc_seq_pkg::word_step; // [RL14]
         bi.wdata = save_pc;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         jump_valid   <= 1'b0;
         jump_addr    <= 32'h0000_0000;
         jump_delayed <= 1'b0;
         sp_write     <= 1'b0;
         sp_value     <= 32'h0000_0000;
      end else if (ce) begin
         jump_valid   <= state == exc_seq_pkg::st_jump; // [RL4]
         jump_addr    <= save_pc;
         jump_delayed <= 1'b0; // [RL4]
         sp_write     <= state == exc_seq_pkg::st_jump;
         sp_value     <= sp; // [RL14]
      end
   end
endmodule

// File: dv/exc_seq_assertions.sv
`timescale 1ns/1ps
module exc_seq_assertions (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        dec_valid,
   input wire logic [4:0]  dec_class,
   input wire logic [31:0] status_register,
   input wire logic [31:0] stack_pointer,
   input wire logic        fpu_exc_req,
   input wire logic        busy,
   input wire logic        take_bus_err,
   input wire logic        take_irq,
   input wire logic        take_fpu,
   input wire logic        jump_valid,
   input wire logic [31:0] jump_addr,
   input wire logic        jump_delayed,
   input wire logic        sp_write,
   input wire logic [31:0] sp_value,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic        mem_ack,
   input wire logic [31:0] mem_rdata
);
   logic        prev_dly;
   logic        prev_ctl;
   logic [31:0] last_rd;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prev_dly <= 1'b0;
         prev_ctl <= 1'b0;
      end else if (dec_valid && !busy) begin
         prev_dly <= dec_class inside {[5'h02:5'h0B]} && !(take_irq || take_bus_err || take_fpu);
         prev_ctl <= dec_class inside {[5'h0F:5'h16]} && !(take_irq || take_bus_err || take_fpu);
      end else if (jump_valid) begin
         prev_dly <= 1'b0;
         prev_ctl <= 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         last_rd <= 32'h0000_0000;
      end else if (mem_req && mem_ack && !mem_we) begin
         last_rd <= mem_rdata;
      end
   end
   sequence sr_push;
      mem_req && mem_we && mem_addr == stack_pointer - 32'h4 && mem_wdata == status_register;
   endsequence
   sequence pc_push;
      mem_req && mem_we && mem_addr == stack_pointer - 32'h8;
   endsequence
   a_sr_first: assert property ($rose(busy) |-> ##[0:3] sr_push) else $error("status push missing");
   a_pc_second: assert property (sr_push ##0 mem_ack |-> ##[1:4] pc_push) else $error("pc push missing");
   a_vec_third: assert property (pc_push ##0 mem_ack |-> ##[1:4] (mem_req && !mem_we)) else $error("no fetch");
   a_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
      else $error("request dropped or changed");
   a_jump_plain: assert property (jump_valid |-> jump_addr == last_rd && !jump_delayed)
      else $error("bad handler jump");
   a_sp_final: assert property (sp_write |-> sp_value == stack_pointer - 32'h8) else $error("bad sp");
   a_slot_bad: assert property (dec_valid && !busy && prev_dly && dec_class inside {[5'h01:5'h0E]} |=> busy)
      else $error("slot code not trapped");
   a_slot_hold: assert property (dec_valid && !busy && prev_dly |-> !(take_irq || take_bus_err || take_fpu))
      else $error("event taken in slot");
   a_ctl_defer: assert property (dec_valid && !busy && prev_ctl |-> !take_irq && !take_bus_err)
      else $error("event not deferred");
   a_ctl_fpu: assert property (dec_valid && !busy && prev_ctl && fpu_exc_req && dec_class == 5'h00 |-> take_fpu)
      else $error("fpu event not taken");
endmodule
bind instruction_exception_sequencer exc_seq_assertions exc_seq_assertions_inst (.*);

// File: dv/exc_mem_model.sv
`timescale 1ns/1ps
module exc_mem_model (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic [1:0]  lag,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic            mem_ack,
   output logic [31:0]     mem_rdata,
   output logic            mem_addr_err
);
   logic [1:0]  cnt;
   logic [31:0] wa[$];
   logic [31:0] wd[$];
   logic [31:0] ra[$];
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mem_ack <= 1'b0;
         mem_addr_err <= 1'b0;
         mem_rdata <= 32'h0;
         cnt <= 2'h0;
      end else if (mem_req && !mem_ack && cnt >= lag) begin
         mem_ack <= 1'b1;
         mem_addr_err <= mem_addr[1:0] != 2'h0;
         mem_rdata <= mem_addr ^ 32'hC0DE_0000;
         cnt <= 2'h0;
         if (mem_we) begin
            wa.push_back(mem_addr);
            wd.push_back(mem_wdata);
         end else begin
            ra.push_back(mem_addr);
         end
      end else begin
         mem_ack <= 1'b0;
         mem_addr_err <= ~mem_addr_err;
         mem_rdata <= ~mem_rdata;
         cnt <= (mem_req && !mem_ack) ? cnt + 2'h1 : 2'h0;
      end
   end
endmodule

// File: dv/instruction_exception_sequencer_bench.sv
`timescale 1ns/1ps
module instruction_exception_sequencer_bench;
   logic        clk = 1'b0, rstn = 1'b0, dec_valid = 1'b0, bus_err_req = 1'b0, irq_req = 1'b0, fpu_exc_req = 1'b0;
   logic [4:0]  dec_class = 5'h00;
   logic [7:0]  dec_trap_vec = 8'h00, irq_vec = 8'h40, fpu_vec = 8'h41;
   logic [31:0] dec_pc = 32'h0, dec_next_pc = 32'h2, branch_target = 32'h0, status_register = 32'h0;
   logic [31:0] stack_pointer = 32'h0, vector_base_register = 32'h0;
   logic [1:0]  lag = 2'h0;
   logic [2:0]  tk;
   logic        busy, take_bus_err, take_irq, take_fpu, jump_valid, jump_delayed, sp_write;
   logic        mem_req, mem_we, mem_ack, mem_addr_err;
   logic [31:0] jump_addr, sp_value, mem_addr, mem_wdata, mem_rdata;
   logic [31:0] jumps[$];
   integer      seed = 61453, errors = 0, tests_run = 0, k;
   always #5 clk = ~clk;
   instruction_exception_sequencer instruction_exception_sequencer_inst (.*, .ce(1'b1));
   exc_mem_model exc_mem_model_inst (.*);
   always @(posedge clk) if (jump_valid === 1'b1) jumps.push_back(jump_addr);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   function automatic logic is_dly(input logic [4:0] c);
      return c inside {[5'h02:5'h0B]};
   endfunction
   function automatic logic [7:0] exp_vec(input logic [4:0] br, input logic [4:0] c);
      return is_dly(br) ? exc_seq_pkg::vec_slot_illegal : c == 5'h0E ? dec_trap_vec : exc_seq_pkg::vec_gen_illegal;
   endfunction
   function automatic logic [2:0] ev_of(input int n);
      return n[0] ? 3'h2 : (n < 8 ? 3'h5 : 3'h1);
   endfunction
   task automatic issue(input logic [4:0] c);
      dec_class = c;
      dec_valid = 1'b1;
      dec_pc = $random(seed) & 32'hFFFF_FFFE;
      dec_next_pc = dec_pc + 32'h2;
      #4 tk = {take_bus_err, take_irq, take_fpu};
      @(negedge clk);
   endtask
   task automatic settle;
      int n;
      n = 0;
      dec_valid = 1'b0;
      do @(negedge clk); while (busy !== 1'b0 && ++n < 400);
   endtask
   task automatic entry(input logic [4:0] br, input logic [4:0] c, input int nj, input logic [1:0] mis);
      int n;
      logic [31:0] pc;
      logic [7:0]  v;
      jumps.delete();
      exc_mem_model_inst.wa.delete();
      exc_mem_model_inst.wd.delete();
      exc_mem_model_inst.ra.delete();
      status_register = $random(seed);
      stack_pointer = ($random(seed) & 32'h7FFF_FFFC) | 32'h100 | {30'h0, mis[0], 1'b0};
      vector_base_register = ($random(seed) & 32'h7FFF_FFFC) | {30'h0, mis[1], 1'b0};
      dec_trap_vec = $random(seed);
      branch_target = $random(seed) & 32'hFFFF_FFFE;
      lag = $random(seed);
      issue(br);
      issue(c);
      pc = is_dly(br) ? branch_target : c == 5'h0E ? dec_next_pc : dec_pc;
      settle;
      n = 0;
      while (jumps.size() < nj && n++ < 400) @(negedge clk);
      repeat (30) @(negedge clk);
      for (n = 0; n < nj; n++) begin
         v = n > 0 ? exc_seq_pkg::vec_addr_error : exp_vec(br, c);
         check(exc_mem_model_inst.wa[2*n], stack_pointer - 32'h4);
         check(exc_mem_model_inst.wd[2*n], status_register);
         check(exc_mem_model_inst.wa[2*n+1], stack_pointer - 32'h8);
         check(exc_mem_model_inst.ra[n], vector_base_register + {22'h0, v, 2'h0});
         check(jumps[n], exc_mem_model_inst.ra[n] ^ 32'hC0DE_0000);
      end
      if (mis == 2'h0) check(exc_mem_model_inst.wd[1], pc);
      check(32'(jumps.size()), 32'(nj));
      $display("entry %h after %h done", c, br);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      for (k = 0; k < 6; k++) entry(5'h00, k < 4 ? 5'h0E : 5'h01, 1, 2'h0);
      for (k = 0; k < 14; k++) entry(5'(5'h02 + k % 10), 5'(5'h01 + k), 1, 2'h0);
      entry(5'h00, 5'h0E, 2, 2'h1);
      entry(5'h04, 5'h01, 2, 2'h2);
      for (k = 0; k < 18; k++) begin
         issue(k < 8 ? 5'(5'h0F + k) : 5'(k - 6));
         {bus_err_req, irq_req, fpu_exc_req} = ev_of(k);
         issue(5'h00);
         check({29'h0, tk}, {31'h0, k < 8 && !k[0]});
         if (tk[0]) fpu_exc_req = 1'b0;
         settle;
         issue(5'h00);
         check({29'h0, tk}, {29'h0, ev_of(k) & 3'h6} | {31'h0, k >= 8 && !k[0]});
         {bus_err_req, irq_req, fpu_exc_req} = 3'h0;
         settle;
         $display("event case %0d done", k);
      end
      stop_test;
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      stop_test;
   end
endmodule
